// ===== rtl/pifb_flag_bank.v
// peripheral interrupt request flag bank with apb register access
// Contract
// - oscillator fail-safe event sets its flag; stays until software clears
// - clock switch ready sets its flag; stays until software clears
// - conversion complete sets converter flag; zero while none pending
// - unimplemented request bits always read zero
// - every flag resets to zero on any reset
// - enabled rising or falling zero-cross event sets its flag
// - comparator flags set on interrupt; second exists only on larger variant
// - receive flag is read-only, high while receive buffer holds data
// - transmit flag is read-only, high while transmit buffer has room
// - transmit flag shows room only; shift-empty status is separate
// - bus collision sets collision flag until software clears
// - synchronous port completion sets its flag; software clears
// - timer8 flag on postscale overflow, or period match at ratio one
// - timer16 overflow sets its flag until software clears
// - four logic cell flags in upper bits of fifth register
// - timer16 gate going inactive sets gate done flag
// - hardware-set flags are read/write; software clears by writing zero
// - no request interrupts without its enable and global enable
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps

`include "pifb_consts.vh"

module pifb_flag_bank #(
    parameter HAS_COMP_TWO = 1
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        osc_fail_evt,
    input  wire        clk_switch_ready_evt,
    input  wire        conv_done_evt,
    input  wire        zc_rise_evt,
    input  wire        zc_fall_evt,
    input  wire        comp_one_evt,
    input  wire        comp_two_evt,
    input  wire        rx_buf_not_empty,
    input  wire        tx_buf_has_room,
    input  wire        tx_shift_empty,
    input  wire        sync_collision_evt,
    input  wire        sync_done_evt,
    input  wire        timer8_postscale_ovf_evt,
    input  wire        timer8_period_match_evt,
    input  wire        timer8_ratio_one,
    input  wire        timer16_ovf_evt,
    input  wire        timer16_gate,
    input  wire [3:0]  logic_cell_evt,
    output wire        periph_irq_req
);

    // implemented bits; the comparator two flag vanishes on the small variant
    localparam [7:0]  IMPL_2_EFF = (HAS_COMP_TWO != 0) ? `PIFB_IMPL_2
                                   : (`PIFB_IMPL_2 & ~(8'h01 << `PIFB_BIT_COMP_TWO));
    localparam [39:0] IMPL_MASK  = {`PIFB_IMPL_5, `PIFB_IMPL_4, `PIFB_IMPL_3,
                                    IMPL_2_EFF, `PIFB_IMPL_1};
    localparam [39:0] RO_MASK    = {8'h00, 8'h00, `PIFB_RO_3, 8'h00, 8'h00};
    localparam [39:0] FLAG_RST   = {5{`PIFB_RST_FLAGS}};
    localparam [39:0] ENA_RST    = {5{`PIFB_RST_ENABLE}};

    reg  [39:0] flag_ff;
    reg  [39:0] nxt_flag;
    reg  [39:0] enable_ff;
    reg  [39:0] nxt_enable;
    reg  [7:0]  control_ff;
    reg  [7:0]  nxt_control;
    reg         gate_prev_ff;
    reg         shift_empty_ff;
    reg  [31:0] prdata_ff;
    reg  [31:0] nxt_prdata;
    reg         pready_ff;
    reg         pslverr_ff;
    reg         nxt_pslverr;
    reg         irq_ff;
    reg  [39:0] hw_set;
    reg  [39:0] hw_level;
    reg  [4:0]  flag_wr;
    reg  [4:0]  enable_wr;
    reg         control_wr;
    reg         addr_hit;
    wire        setup_phase;
    wire        access_done;
    wire        lane0_wr;
    wire        gate_fall;
    wire        zc_event;
    wire        timer8_event;
    wire        irq_any;

    // every register is a plain flop, so the bank never stretches an access;
    // a wait state would only hold the master without buying anything
    // the read value is captured at the setup edge, so an event landing on
    // that very edge is seen by the next read, not this one
    // hazard: a master that drops psel early still gets pready one cycle
    // later; the write then does not land because psel is low
    // apb handshake: one wait-free access cycle after each setup cycle
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & pready_ff;
    // registers are 8 bits wide, so only byte lane 0 carries data
    assign lane0_wr    = access_done & pwrite & pstrb[0];

    // writes to unmapped offsets and to the status word fall to the default
    // branch and change nothing; the error flag comes from the read decode
    // a cleared strobe for lane 0 leaves every register untouched
    // register write decode
    always @* begin
        flag_wr    = 5'h00;
        enable_wr  = 5'h00;
        control_wr = 1'b0;
        case (paddr)
            `PIFB_OFF_FLAGS_1: begin
                flag_wr[0] = lane0_wr;
            end
            `PIFB_OFF_FLAGS_2: begin
                flag_wr[1] = lane0_wr;
            end
            `PIFB_OFF_FLAGS_3: begin
                flag_wr[2] = lane0_wr;
            end
            `PIFB_OFF_FLAGS_4: begin
                flag_wr[3] = lane0_wr;
            end
            `PIFB_OFF_FLAGS_5: begin
                flag_wr[4] = lane0_wr;
            end
            `PIFB_OFF_ENABLE_1: begin
                enable_wr[0] = lane0_wr;
            end
            `PIFB_OFF_ENABLE_2: begin
                enable_wr[1] = lane0_wr;
            end
            `PIFB_OFF_ENABLE_3: begin
                enable_wr[2] = lane0_wr;
            end
            `PIFB_OFF_ENABLE_4: begin
                enable_wr[3] = lane0_wr;
            end
            `PIFB_OFF_ENABLE_5: begin
                enable_wr[4] = lane0_wr;
            end
            `PIFB_OFF_CONTROL: begin
                control_wr = lane0_wr;
            end
            default: begin
                control_wr = 1'b0;
            end
        endcase
    end

    // the previous gate level resets low, so a gate that is already low at
    // reset release cannot fake an end of acquisition
    // limitation: a gate that is high at release and falls before the first
    // clock edge never sets the flag, though it is a real end of acquisition
    // gate fall detect
    assign gate_fall = gate_prev_ff & ~timer16_gate;

    // both edge enables reset low, so no zero-cross flag appears until
    // software picks at least one edge
    // edge enables qualify
    assign zc_event = (zc_rise_evt & control_ff[`PIFB_CTL_ZC_RISE_EN]) |
                      (zc_fall_evt & control_ff[`PIFB_CTL_ZC_FALL_EN]);

    assign timer8_event = timer8_ratio_one ? timer8_period_match_evt
                                           : timer8_postscale_ovf_evt;

    // events are taken as levels: each high cycle sets the flag again, so a
    // held event keeps the flag up even against software clears
    // status levels go in a separate vector since they are copied, not set
    // map every peripheral event onto its flag position
    always @* begin
        hw_set   = 40'h00_0000_0000;
        hw_level = 40'h00_0000_0000;
        hw_set[`PIFB_BIT_OSC_FAIL]        = osc_fail_evt;
        hw_set[`PIFB_BIT_CLK_SW]          = clk_switch_ready_evt;
        hw_set[`PIFB_BIT_CONV]            = conv_done_evt;
        hw_set[8 + `PIFB_BIT_ZERO_X]      = zc_event;
        hw_set[8 + `PIFB_BIT_COMP_TWO]    = comp_two_evt;
        hw_set[8 + `PIFB_BIT_COMP_ONE]    = comp_one_evt;
        hw_set[16 + `PIFB_BIT_COLLISION]  = sync_collision_evt;
        hw_set[16 + `PIFB_BIT_SYNC_EVT]   = sync_done_evt;
        hw_set[24 + `PIFB_BIT_TIMER8]     = timer8_event;
        hw_set[24 + `PIFB_BIT_TIMER16]    = timer16_ovf_evt;
        hw_set[32 + `PIFB_BIT_CELL_LO +: 4] = logic_cell_evt;
        hw_set[32 + `PIFB_BIT_GATE_DONE]  = gate_fall;
        hw_level[16 + `PIFB_BIT_RX_PEND]  = rx_buf_not_empty;
        hw_level[16 + `PIFB_BIT_TX_ROOM]  = tx_buf_has_room;
    end

    // priority per bit: unimplemented, then read-only status, then the
    // hardware set, then the software write, then hold
    // putting the set above the write means a clear in the same cycle as
    // an event loses, so no event is ever dropped; the cost is that
    // software must read back to be sure a clear took effect
    // per-bit next state of flags and enables
    genvar gi;
    generate
        for (gi = 0; gi < 40; gi = gi + 1) begin : g_bit
            always @* begin
                if (IMPL_MASK[gi] == 1'b0) begin
                    nxt_flag[gi] = 1'b0;
                end else if (RO_MASK[gi]) begin
                    nxt_flag[gi] = hw_level[gi];
                end else if (hw_set[gi]) begin
                    nxt_flag[gi] = 1'b1;
                end else if (flag_wr[gi / 8]) begin
                    nxt_flag[gi] = pwdata[gi % 8];
                end else begin
                    nxt_flag[gi] = flag_ff[gi];
                end
            end

            always @* begin
                if (IMPL_MASK[gi] == 1'b0) begin
                    nxt_enable[gi] = 1'b0;
                end else if (enable_wr[gi / 8]) begin
                    nxt_enable[gi] = pwdata[gi % 8];
                end else begin
                    nxt_enable[gi] = enable_ff[gi];
                end
            end
        end
    endgenerate

    // unused control bits are masked on write so they always read zero
    // control register next state
    always @* begin
        if (control_wr) begin
            nxt_control = pwdata[7:0] & `PIFB_CTL_MASK;
        end else begin
            nxt_control = control_ff;
        end
    end

    // enables exist only on implemented bits, so a stray enable write
    // cannot gate a bit that never sets; the request is registered below
    // and so appears one cycle after the flag
    // enable and global gating
    assign irq_any = (|(flag_ff & enable_ff)) & control_ff[`PIFB_CTL_GLOBAL_EN];

    // upper data bits stay zero for every register, mapped or not
    // an unmapped read gives zero data together with the error flag
    // read data and error answer, prepared in the setup cycle
    always @* begin
        nxt_prdata = 32'h0000_0000;
        addr_hit   = 1'b1;
        case (paddr)
            `PIFB_OFF_FLAGS_1: begin
                nxt_prdata[7:0] = flag_ff[7:0];
            end
            `PIFB_OFF_FLAGS_2: begin
                nxt_prdata[7:0] = flag_ff[15:8];
            end
            `PIFB_OFF_FLAGS_3: begin
                nxt_prdata[7:0] = flag_ff[23:16];
            end
            `PIFB_OFF_FLAGS_4: begin
                nxt_prdata[7:0] = flag_ff[31:24];
            end
            `PIFB_OFF_FLAGS_5: begin
                nxt_prdata[7:0] = flag_ff[39:32];
            end
            `PIFB_OFF_ENABLE_1: begin
                nxt_prdata[7:0] = enable_ff[7:0];
            end
            `PIFB_OFF_ENABLE_2: begin
                nxt_prdata[7:0] = enable_ff[15:8];
            end
            `PIFB_OFF_ENABLE_3: begin
                nxt_prdata[7:0] = enable_ff[23:16];
            end
            `PIFB_OFF_ENABLE_4: begin
                nxt_prdata[7:0] = enable_ff[31:24];
            end
            `PIFB_OFF_ENABLE_5: begin
                nxt_prdata[7:0] = enable_ff[39:32];
            end
            `PIFB_OFF_CONTROL: begin
                nxt_prdata[7:0] = control_ff;
            end
            `PIFB_OFF_STATUS: begin
                nxt_prdata[`PIFB_STS_SHIFT_EMPTY] = shift_empty_ff;
                nxt_prdata[`PIFB_STS_IRQ_PEND]    = irq_ff;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
        // unmapped: data zero, error flagged
        nxt_pslverr = ~addr_hit;
    end

    // reset only loads constants; the status copies restart from zero and
    // catch up one cycle after release
    // all state resets to zero
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff        <= FLAG_RST;
            enable_ff      <= ENA_RST;
            control_ff     <= `PIFB_RST_CONTROL;
            gate_prev_ff   <= 1'b0;
            shift_empty_ff <= 1'b0;
            irq_ff         <= 1'b0;
        end else begin
            flag_ff        <= nxt_flag;
            enable_ff      <= nxt_enable;
            control_ff     <= nxt_control;
            gate_prev_ff   <= timer16_gate;
            shift_empty_ff <= tx_shift_empty;
            irq_ff         <= irq_any;
        end
    end

    // answer flops clear outside the access cycle so a stale read value
    // never stands on the bus; writes return zero data
    // apb answer flops; pready is high only in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup_phase;
            if (setup_phase) begin
                // read data snapshot is one cycle old at the access edge
                prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
                pslverr_ff <= nxt_pslverr;
            end else begin
                prdata_ff  <= 32'h0000_0000;
                pslverr_ff <= 1'b0;
            end
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign periph_irq_req = irq_ff;

endmodule // pifb_flag_bank

// ===== rtl/pifb_consts.vh
// register map, field positions, masks and reset values of the flag bank
`ifndef PIFB_CONSTS_VH
`define PIFB_CONSTS_VH

// apb byte offsets, one aligned word per register
`define PIFB_OFF_FLAGS_1    8'h00
`define PIFB_OFF_FLAGS_2    8'h04
`define PIFB_OFF_FLAGS_3    8'h08
`define PIFB_OFF_FLAGS_4    8'h0c
`define PIFB_OFF_FLAGS_5    8'h10
`define PIFB_OFF_ENABLE_1   8'h14
`define PIFB_OFF_ENABLE_2   8'h18
`define PIFB_OFF_ENABLE_3   8'h1c
`define PIFB_OFF_ENABLE_4   8'h20
`define PIFB_OFF_ENABLE_5   8'h24
`define PIFB_OFF_CONTROL    8'h28
`define PIFB_OFF_STATUS     8'h2c

// flag positions in periph_request_flags_1
`define PIFB_BIT_OSC_FAIL   7
`define PIFB_BIT_CLK_SW     6
`define PIFB_BIT_CONV       0
// flag positions in periph_request_flags_2
`define PIFB_BIT_ZERO_X     6
`define PIFB_BIT_COMP_TWO   1
`define PIFB_BIT_COMP_ONE   0
// flag positions in periph_request_flags_3
`define PIFB_BIT_RX_PEND    5
`define PIFB_BIT_TX_ROOM    4
`define PIFB_BIT_COLLISION  1
`define PIFB_BIT_SYNC_EVT   0
// flag positions in periph_request_flags_4
`define PIFB_BIT_TIMER8     1
`define PIFB_BIT_TIMER16    0
// flag positions in periph_request_flags_5
`define PIFB_BIT_CELL_LO    4
`define PIFB_BIT_GATE_DONE  0

// implemented bits per request register
`define PIFB_IMPL_1         8'hc1
`define PIFB_IMPL_2         8'h43
`define PIFB_IMPL_3         8'h33
`define PIFB_IMPL_4         8'h03
`define PIFB_IMPL_5         8'hf1
// read-only (status driven) bits per request register
`define PIFB_RO_3           8'h30

// control register fields
`define PIFB_CTL_GLOBAL_EN  0
`define PIFB_CTL_ZC_RISE_EN 1
`define PIFB_CTL_ZC_FALL_EN 2
`define PIFB_CTL_MASK       8'h07
// status register fields
`define PIFB_STS_SHIFT_EMPTY 0
`define PIFB_STS_IRQ_PEND    1

// reset values
`define PIFB_RST_FLAGS      8'h00
`define PIFB_RST_ENABLE     8'h00
`define PIFB_RST_CONTROL    8'h00

`endif

// ===== verification/pifb_flag_bank_checker.sv
// port-level assertions for the peripheral flag bank
`timescale 1ns/10ps
`include "pifb_consts.vh"
module pifb_flag_bank_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        rx_buf_not_empty,
    input wire        tx_buf_has_room,
    input wire        tx_shift_empty,
    input wire        periph_irq_req
);
    wire rd_cyc;
    // completed read access
    assign rd_cyc = psel && penable && pready && !pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // zero wait states, one cycle answer
    property p_ready_next; psel && !penable |=> pready; endproperty
    a_ready_next: assert property (p_ready_next) else $error("pready late");
    property p_ready_once; pready |=> !pready; endproperty
    a_ready_once: assert property (p_ready_once) else $error("pready held");
    property p_reset_quiet; $rose(presetn) |-> !periph_irq_req && !pready; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("busy after reset");
    property p_unused_1;
        rd_cyc && paddr == `PIFB_OFF_FLAGS_1 |-> (prdata[7:0] & ~`PIFB_IMPL_1) == 8'h00;
    endproperty
    a_unused_1: assert property (p_unused_1) else $error("flags1 unused bit");
    property p_unused_5;
        rd_cyc && paddr == `PIFB_OFF_FLAGS_5 |-> (prdata[7:0] & ~`PIFB_IMPL_5) == 8'h00;
    endproperty
    a_unused_5: assert property (p_unused_5) else $error("flags5 unused bit");
    property p_rx; rd_cyc && paddr == `PIFB_OFF_FLAGS_3 |-> prdata[5] == $past(rx_buf_not_empty, 2);
    endproperty
    a_rx: assert property (p_rx) else $error("rx flag wrong");
    property p_tx; rd_cyc && paddr == `PIFB_OFF_FLAGS_3 |-> prdata[4] == $past(tx_buf_has_room, 2);
    endproperty
    a_tx: assert property (p_tx) else $error("tx flag wrong");
    property p_shift;
        rd_cyc && paddr == `PIFB_OFF_STATUS |-> prdata[0] == $past(tx_shift_empty, 2);
    endproperty
    a_shift: assert property (p_shift) else $error("shift status wrong");
endmodule // pifb_flag_bank_checker

bind pifb_flag_bank pifb_flag_bank_checker pifb_flag_bank_checker_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
    .rx_buf_not_empty, .tx_buf_has_room, .tx_shift_empty, .periph_irq_req
);

// ===== verification/pifb_periph_model.sv
// behavioural model of the peripherals that raise flags
`timescale 1ns/10ps
module pifb_periph_model (
    input  wire        pclk,
    input  wire        presetn,
    input  wire [19:0] fire,
    output reg  [15:0] evt_ff,
    output wire        rx_buf_not_empty,
    output wire        tx_buf_has_room,
    output wire        tx_shift_empty
);
    reg [1:0] rx_cnt_ff;
    reg [1:0] tx_cnt_ff;
    // events are one-cycle pulses; the tx buffer is two deep, the rx count has no cap and wraps after three
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_ff <= 16'h0000;
            rx_cnt_ff <= 2'h0;
            tx_cnt_ff <= 2'h0;
        end else begin
            evt_ff <= fire[15:0];
            rx_cnt_ff <= rx_cnt_ff + 2'(fire[16]) - 2'(fire[17] && rx_cnt_ff != 2'h0);
            tx_cnt_ff <= tx_cnt_ff + 2'(fire[18] && tx_cnt_ff != 2'h2)
                - 2'(fire[19] && tx_cnt_ff != 2'h0);
        end
    end
    assign rx_buf_not_empty = rx_cnt_ff != 2'h0;
    assign tx_buf_has_room  = tx_cnt_ff != 2'h2;
    assign tx_shift_empty   = tx_cnt_ff == 2'h0;
endmodule // pifb_periph_model

// ===== verification/testbench.sv
// self-checking bench for the peripheral flag bank
`timescale 1ns/10ps
module testbench;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic [19:0] fire = 20'h0;
    logic        ratio_one = 1'b0, gate = 1'b0, pready, pslverr, periph_irq_req, err;
    wire  [15:0] evt;
    wire         rx_ne, tx_room, sh_empty;
    int          failures = 0, compares = 0;
    logic [7:0]  impl [5] = '{8'hc1, 8'h43, 8'h13, 8'h03, 8'hf1};
    logic [7:0]  ev_addr [16] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04, 8'h08,
                                  8'h08, 8'h0c, 8'h0c, 8'h0c, 8'h10, 8'h10, 8'h10, 8'h10};
    logic [7:0]  ev_mask [16] = '{8'h80, 8'h40, 8'h01, 8'h00, 8'h00, 8'h01, 8'h02, 8'h02,
                                  8'h01, 8'h02, 8'h00, 8'h01, 8'h10, 8'h20, 8'h40, 8'h80};
    always #2 pclk = ~pclk;
    pifb_flag_bank pifb_flag_bank_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .osc_fail_evt(evt[0]), .clk_switch_ready_evt(evt[1]), .conv_done_evt(evt[2]),
        .zc_rise_evt(evt[3]), .zc_fall_evt(evt[4]), .comp_one_evt(evt[5]),
        .comp_two_evt(evt[6]), .rx_buf_not_empty(rx_ne), .tx_buf_has_room(tx_room),
        .tx_shift_empty(sh_empty), .sync_collision_evt(evt[7]), .sync_done_evt(evt[8]),
        .timer8_postscale_ovf_evt(evt[9]), .timer8_period_match_evt(evt[10]),
        .timer8_ratio_one(ratio_one), .timer16_ovf_evt(evt[11]), .timer16_gate(gate),
        .logic_cell_evt(evt[15:12]), .periph_irq_req
    );
    pifb_periph_model pifb_periph_model_inst (
        .pclk, .presetn, .fire, .evt_ff(evt), .rx_buf_not_empty(rx_ne),
        .tx_buf_has_room(tx_room), .tx_shift_empty(sh_empty)
    );
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; waits on pready without a bound
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= addr; pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        apb(1'b0, addr, 32'h0);
        check(what, rd, {24'h0, exp});
    endtask
    task automatic pulse(input logic [19:0] b);
        @(posedge pclk) fire <= b;
        @(posedge pclk) fire <= 20'h0;
        repeat (2) @(posedge pclk);
    endtask
    task automatic t_reset;
        for (int i = 0; i < 5; i++) begin
            rchk("flags at reset", 8'(4 * i), i == 2 ? 8'h10 : 8'h00);
            rchk("enable at reset", 8'(8'h14 + 4 * i), 8'h00);
            apb(1'b1, 8'(4 * i), 32'hff);
            rchk("flags all ones", 8'(4 * i), impl[i]);
            apb(1'b1, 8'(4 * i), 32'h0);
            rchk("flags cleared", 8'(4 * i), i == 2 ? 8'h10 : 8'h00);
        end
    endtask
    task automatic t_events;
        for (int b = 0; b < 16; b++) begin
            if (ev_mask[b] != 8'h00) begin
                pulse(20'(1) << b);
                repeat (4) @(posedge pclk);
                rchk("flag held", ev_addr[b], ev_mask[b] | (b == 7 || b == 8 ? 8'h10 : 8'h00));
                apb(1'b1, ev_addr[b], 32'h0);
                rchk("flag cleared", ev_addr[b], b == 7 || b == 8 ? 8'h10 : 8'h00);
            end
        end
    endtask
    task automatic t_zc_timer;
        pulse(20'h00008);
        rchk("zc off", 8'h04, 8'h00);
        apb(1'b1, 8'h28, 32'h06);
        for (int k = 3; k < 5; k++) begin
            pulse(20'(1) << k);
            rchk("zc edge", 8'h04, 8'h40);
            apb(1'b1, 8'h04, 32'h0);
        end
        pulse(20'h00400);
        rchk("match ignored", 8'h0c, 8'h00);
        @(posedge pclk) ratio_one <= 1'b1;
        pulse(20'h00200);
        rchk("postscale ignored", 8'h0c, 8'h00);
        pulse(20'h00400);
        rchk("match at one", 8'h0c, 8'h02);
        apb(1'b1, 8'h0c, 32'h0);
        @(posedge pclk) gate <= 1'b1;
        repeat (3) @(posedge pclk);
        rchk("gate active", 8'h10, 8'h00);
        gate <= 1'b0;
        repeat (3) @(posedge pclk);
        rchk("gate done", 8'h10, 8'h01);
        apb(1'b1, 8'h10, 32'h0);
    endtask
    task automatic t_buffers;
        pulse(20'h10000);
        pulse(20'h10000);
        pulse(20'h20000);
        rchk("rx one left", 8'h08, 8'h30);
        pulse(20'h20000);
        apb(1'b1, 8'h08, 32'h30);
        rchk("rx empty", 8'h08, 8'h10);
        for (int n = 0; n < 4 && tx_room === 1'b1; n++) pulse(20'h40000);
        rchk("tx full", 8'h08, 8'h00);
        pulse(20'h80000);
        rchk("tx room", 8'h08, 8'h10);
        rchk("shift busy", 8'h2c, 8'h00);
        pulse(20'h80000);
        rchk("shift empty", 8'h2c, 8'h01);
    endtask
    task automatic t_irq;
        apb(1'b1, 8'h14, 32'h01);
        pulse(20'h00004);
        check("irq no global", {31'h0, periph_irq_req}, 32'h0);
        apb(1'b1, 8'h28, 32'h01);
        repeat (2) @(posedge pclk);
        check("irq raised", {31'h0, periph_irq_req}, 32'h1);
        rchk("irq pending status", 8'h2c, 8'h03);
        // clear and event land on one edge
        fork
            apb(1'b1, 8'h00, 32'h0);
            pulse(20'h00004);
        join
        rchk("set beats clear", 8'h00, 8'h01);
        apb(1'b1, 8'h00, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq dropped", {31'h0, periph_irq_req}, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        pulse(20'h00001);
        @(posedge pclk) presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        rchk("flags after rerun", 8'h00, 8'h00);
    endtask
    task automatic give_verdict;
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_events;
        t_zc_timer;
        t_buffers;
        t_irq;
        give_verdict;
    end
    // watchdog well beyond the expected run
    initial begin
        #40000;
        failures++;
        give_verdict;
    end
endmodule // testbench
